// file: sim/host_port_model.sv
// Host model for the queue pins: selects, sector strobes, words, partial reset.
// Assumes one clock and a bench that calls one task at a time.
`timescale 1ns/1ns
`default_nettype none
module host_port_model (
    input wire logic clk,
    output logic [3:0] wq,
    output logic wae,
    output logic [3:0] rq,
    output logic rae,
    output logic wsec,
    output logic rsec,
    output logic wr,
    output logic rd,
    output logic sop,
    output logic eop,
    output logic pend,
    output logic prs_n
);
    // All pins idle until a task drives them
    initial begin
        {wq, wae, rq, rae, wsec, rsec, wr, rd, sop, eop, pend} = '0;
        prs_n = 1'b1;
    end
    // Queue select, one cycle wide, never beside a sector strobe
    task automatic sel(input bit w, input logic [3:0] q);
        @(posedge clk);
        if (w) wq <= q;
        else rq <= q;
        wae <= w;
        rae <= !w;
        @(posedge clk);
        {wae, rae} <= 2'h0;
    endtask
    // Sector strobe; the address only carries the sector bit here
    task automatic sect(input bit w, input logic [3:0] q);
        @(posedge clk);
        if (w) wq <= q;
        else rq <= q;
        wsec <= w;
        rsec <= !w;
        @(posedge clk);
        {wsec, rsec} <= 2'h0;
    endtask
    // Word bursts; a packet is marked whole before any queue switch
    task automatic push(input int n, input bit p);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            wr <= 1'b1;
            sop <= p && i == 0;
            eop <= p && i == n - 1;
        end
        @(posedge clk);
        {wr, sop, eop} <= 3'h0;
    endtask
    task automatic pop(input int n, input bit p);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rd <= 1'b1;
            pend <= p && i == n - 1;
        end
        @(posedge clk);
        {rd, pend} <= 2'h0;
    endtask
    // Partial reset, issued well after both ports chose the queue
    task automatic prst();
        repeat (3) @(posedge clk);
        prs_n <= 1'b0;
        @(posedge clk);
        prs_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// file: sim/test_multi_queue_flag_status.sv
// Self-checking bench: count model per queue against the flag outputs.
// Assumes the design instantiated with a 16-word queue depth.
`timescale 1ns/1ns
`default_nettype none
module test_multi_queue_flag_status;
    logic clk, rst, mrst_n, iw, ow, bm, fm, pk;
    logic [7:0] awaddr, araddr, aeb, afb;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [3:0] wq, rq;
    logic wae, rae, wsec, rsec, wr, rd, sop, eop, pend, prs_n;
    logic ov, ov_oe, aef, aff, prf, aeb_oe, afb_oe;
    logic [7:0] b0, b1;
    int mismatches, checks_done, seed, cnt[16], pkc[16];
    int ae_thr, af_thr, rq_m, wq_m, rs_m, ws_m, q, n;
    bit pmode, poll;

    multi_queue_flag_status #(.QUEUE_DEPTH(16)) multi_queue_flag_status_inst (
        .clk(clk), .rst(rst), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .master_reset_n(mrst_n), .partial_reset_n(prs_n),
        .input_width_select(iw), .output_width_select(ow),
        .bus_match_select(bm), .flag_mode_select(fm),
        .packet_mode_select(pk), .write_queue_address(wq),
        .write_address_enable(wae), .read_queue_address(rq),
        .read_address_enable(rae), .write_flag_sector_strobe(wsec),
        .read_flag_sector_strobe(rsec), .write_strobe(wr), .read_strobe(rd),
        .packet_start_marker(sop), .packet_end_marker(eop),
        .read_packet_end(pend), .output_valid_flag(ov),
        .output_valid_flag_oe(ov_oe), .almost_empty_flag(aef),
        .almost_full_flag(aff), .packet_ready_flag(prf),
        .almost_empty_flag_bus(aeb), .almost_empty_flag_bus_oe(aeb_oe),
        .almost_full_flag_bus(afb), .almost_full_flag_bus_oe(afb_oe));

    host_port_model host_port_model_inst (.clk(clk), .wq(wq), .wae(wae),
        .rq(rq), .rae(rae), .wsec(wsec), .rsec(rsec), .wr(wr), .rd(rd),
        .sop(sop), .eop(eop), .pend(pend), .prs_n(prs_n));

    task automatic close_out();
        if (mismatches == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One bus transfer; readies are sampled settled, acted on at the edge
    task automatic axi(input bit w, input logic [7:0] a, input logic [31:0] v,
                       output logic [31:0] o, output logic [1:0] rs);
        bit tk, tw, dn;
        @(posedge clk);
        if (w) {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'h7};
        else {araddr, arvalid, rready} <= {a, 2'h3};
        for (int i = 0; i < 40; i++) begin
            @(negedge clk);
            tk = w ? awready : arready;
            tw = wready;
            dn = w ? bvalid : rvalid;
            rs = w ? bresp : rresp;
            o = rdata;
            @(posedge clk);
            // Address and data channels let go only when their own ready was seen, the response channel when its valid was
            if (tk) {awvalid, arvalid} <= 2'h0;
            if (tw) wvalid <= 1'b0;
            if (dn) begin
                {bready, rready} <= 2'h0;
                return;
            end
        end
        mismatches++;
        close_out();
    endtask
    function automatic logic aem(int k);
        return pmode ? pkc[k] == 0 : cnt[k] > ae_thr;
    endfunction
    function automatic logic [7:0] bus(int s, bit f);
        for (int i = 0; i < 8; i++)
            bus[i] = f ? cnt[s*8+i] < 16 - af_thr : aem(s * 8 + i);
    endfunction
    // Settle the pin syncs, then compare the four discrete flags, and the buses when direct, with the model
    task automatic fl();
        repeat (8) @(posedge clk);
        @(negedge clk);
        check("ov", cnt[rq_m] == 0, ov);
        check("aef", cnt[rq_m] > ae_thr, aef);
        check("aff", cnt[wq_m] < 16 - af_thr, aff);
        check("prf", !pmode || pkc[rq_m] == 0, prf);
        if (!poll) check("aeb", bus(rs_m, 0), aeb);
        if (!poll) check("afb", bus(ws_m, 1), afb);
    endtask
    task automatic mres(input bit f, p, b, i, o);
        {fm, pk, bm, iw, ow} <= {f, p, b, i, o};
        mrst_n <= 1'b0;
        repeat (5) @(posedge clk);
        mrst_n <= 1'b1;
        repeat (5) @(posedge clk);
        {rq_m, wq_m, rs_m, ws_m} = '0;
        {poll, pmode} = {f, p && !b};
        foreach (cnt[k]) {cnt[k], pkc[k]} = '0;
    endtask
    task automatic wq_push(input int k, m, input bit p);
        host_port_model_inst.sel(1, k[3:0]);
        wq_m = k;
        host_port_model_inst.push(m, p);
        if (cnt[k] + m <= 16) pkc[k] += p;
        cnt[k] = cnt[k] + m > 16 ? 16 : cnt[k] + m;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Hang guard
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        close_out();
    end
    initial begin
        {rst, mrst_n, iw, ow, bm, fm, pk} = 7'h41;
        {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
        {arvalid, rready} = 2'h0;
        {mismatches, checks_done} = '0;
        {ae_thr, af_thr} = {32'h8, 32'h8};
        seed = 54;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        mres(0, 0, 0, 0, 0);
        axi(0, 8'h00, 0, d, r);
        check("ctrl", 32'h1, d);
        axi(0, 8'h04, 0, d, r);
        check("ae_thr", 32'h8, d);
        axi(0, 8'h08, 0, d, r);
        check("af_thr", 32'h8, d);
        axi(1, 8'h04, 32'h2, d, r);
        axi(1, 8'h08, 32'h4, d, r);
        check("wr resp", 32'h0, r);
        {ae_thr, af_thr} = {32'h2, 32'h4};
        axi(0, 8'h04, 0, d, r);
        check("ae_thr", 32'h2, d);
        axi(0, 8'h10, 0, d, r);
        check("unmapped", 32'h0, d);
        check("unmapped resp", 32'h2, r);
        axi(1, 8'h10, 32'h5, d, r);
        check("unmapped wr", 32'h2, r);
        // Random traffic, sector strobes and selects in direct mode
        for (int t = 0; t < 10; t++) begin
            q = $unsigned($random(seed)) % 16;
            n = 1 + $unsigned($random(seed)) % 15;
            wq_push(q, n, 0);
            q = $unsigned($random(seed)) % 16;
            host_port_model_inst.sel(0, q[3:0]);
            rq_m = q;
            n = $unsigned($random(seed)) % 6;
            host_port_model_inst.pop(n, 0);
            cnt[q] = cnt[q] > n ? cnt[q] - n : 0;
            host_port_model_inst.sect(t[0], {t[1], 3'h0});
            if (t[0]) ws_m = t[1];
            else rs_m = t[1];
            fl();
        end
        axi(0, 8'h0C, 0, d, r);
        check("status", {rq_m[3:0], 4'hA, 2'h0}, d[9:0]);
        axi(1, 8'h00, 32'h0, d, r);
        fl();
        check("oe", 3'h0, {ov_oe, aeb_oe, afb_oe});
        axi(1, 8'h00, 32'h1, d, r);
        check("oe on", 32'h7, {ov_oe, aeb_oe, afb_oe});
        wq_push(5, 7, 0);
        host_port_model_inst.sel(0, 4'h5);
        rq_m = 5;
        fl();
        host_port_model_inst.prst();
        cnt[5] = 0;
        fl();
        mres(1, 1, 1, 0, 1);
        axi(0, 8'h0C, 0, d, r);
        check("refused", 3'h4, {d[16], d[5:4]});
        check("pkt", 2'h2, d[1:0]);
        // Polled mode: buses alternate between the two sectors
        // Queue 10 almost full so the two write-side sectors differ
        wq_push(3, 5, 0);
        wq_push(10, 12, 0);
        fl();
        {b0, b1} = {aeb, afb};
        @(negedge clk);
        // Both buses poll in step; the phase is read off the first sample
        d = b0 == bus(0, 0) ? {bus(0, 0), bus(1, 0), bus(0, 1), bus(1, 1)}
                            : {bus(1, 0), bus(0, 0), bus(1, 1), bus(0, 1)};
        check("poll", d[31:16], {b0, aeb});
        check("poll af", d[15:0], {b1, afb});
        mres(0, 1, 0, 0, 0);
        wq_push(9, 3, 1);
        wq_push(9, 1, 1);
        host_port_model_inst.sel(0, 4'h9);
        rq_m = 9;
        host_port_model_inst.sect(0, 4'h8);
        rs_m = 1;
        fl();
        host_port_model_inst.pop(3, 1);
        {cnt[9], pkc[9]} = {32'd1, 32'd1};
        fl();
        host_port_model_inst.pop(1, 1);
        {cnt[9], pkc[9]} = '0;
        fl();
        close_out();
    end
endmodule
`default_nettype wire

// file: verilog/mq_flag_consts.svh
// Constants for the multi-queue flag and status block: queue geometry,
// register offsets, field positions, reset values and cycle counts.
// Assumes it is included by bare name into design files only.
`ifndef MQ_FLAG_CONSTS_SVH
`define MQ_FLAG_CONSTS_SVH

// Queue geometry: 16 queues in two sectors of 8
`define MQ_NQ 16
`define MQ_QW 4
`define MQ_SECT 8

// Read queue change to valid flag tracking the new queue, in clocks
`define MQ_OV_DELAY 2'h2

// Register bus geometry and byte offsets
`define MQ_AXI_AW 8
`define MQ_ADDR_CTRL 8'h00
`define MQ_ADDR_AE 8'h04
`define MQ_ADDR_AF 8'h08
`define MQ_ADDR_STAT 8'h0C

// Control register: bit that lets the valid flag and both flag buses drive their wires
`define MQ_CTRL_DRV 0
`define MQ_CTRL_DRV_RST 1'h1

// Threshold registers: width and reset values
`define MQ_THR_W 16
`define MQ_AE_RST 16'h0008
`define MQ_AF_RST 16'h0008

// Bus responses
`define MQ_RESP_OKAY 2'h0
`define MQ_RESP_SLVERR 2'h2

// Status register field positions
`define MQ_ST_PKT 0
`define MQ_ST_POLL 1
`define MQ_ST_INW 2
`define MQ_ST_OUTW 4
`define MQ_ST_RQ 6
`define MQ_ST_WQ 10
`define MQ_ST_RSEC 14
`define MQ_ST_WSEC 15
`define MQ_ST_CFGERR 16

`endif

// file: verilog/mq_flag_pkg.sv
// Types shared by the multi-queue flag and status block.
// Assumes nothing of its surroundings.
package mq_flag_pkg;

    // Port width chosen by the straps at master reset
    typedef enum logic [1:0] {W9, W18, W36} port_width_e;

endpackage

// file: verilog/multi_queue_flag_status.sv
// Flag and status logic of a 16-queue FIFO, with an AXI4-Lite slave.
// Assumes one clock for both ports, host pins arriving asynchronously,
// and a bench that resolves the valid flag and flag bus wires from their output enables.
`include "mq_flag_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module multi_queue_flag_status #(
    parameter int QUEUE_DEPTH = 1024
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [`MQ_AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`MQ_AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic master_reset_n,
    input wire logic partial_reset_n,
    input wire logic input_width_select,
    input wire logic output_width_select,
    input wire logic bus_match_select,
    input wire logic flag_mode_select,
    input wire logic packet_mode_select,
    input wire logic [`MQ_QW-1:0] write_queue_address,
    input wire logic write_address_enable,
    input wire logic [`MQ_QW-1:0] read_queue_address,
    input wire logic read_address_enable,
    input wire logic write_flag_sector_strobe,
    input wire logic read_flag_sector_strobe,
    input wire logic write_strobe,
    input wire logic read_strobe,
    input wire logic packet_start_marker,
    input wire logic packet_end_marker,
    input wire logic read_packet_end,
    output logic output_valid_flag,
    output logic output_valid_flag_oe,
    output logic almost_empty_flag,
    output logic almost_full_flag,
    output logic packet_ready_flag,
    output logic [`MQ_SECT-1:0] almost_empty_flag_bus,
    output logic almost_empty_flag_bus_oe,
    output logic [`MQ_SECT-1:0] almost_full_flag_bus,
    output logic almost_full_flag_bus_oe
);

    localparam int CW = $clog2(QUEUE_DEPTH + 1);
    localparam int SYNC_W = 2 * `MQ_QW + 16;
    localparam logic [CW-1:0] DEPTH_C = CW'(QUEUE_DEPTH);
    localparam logic [`MQ_THR_W-1:0] DEPTH_T = `MQ_THR_W'(QUEUE_DEPTH);

    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic mrs_n_s, prs_n_s, iw_s, ow_s, bm_s, fm_s, pkt_s;
    logic [`MQ_QW-1:0] wqa_s, rqa_s;
    logic wae_s, rae_s, wfs_s, rfs_s, ws_s, rs_s, psm_s, pem_s, rpe_s;
    logic mr;
    mq_flag_pkg::port_width_e in_w_q, out_w_q;
    logic pkt_req_q, pkt_mode_q, polled_q;
    logic [`MQ_QW-1:0] wq_q, rq_q;
    logic [1:0] ov_dly_q;
    logic in_pkt_q;
    logic rd_sec_q, wr_sec_q;
    logic [`MQ_NQ-1:0] emp_st, ae_st, af_st, pr_st;
    logic [`MQ_NQ-1:0] rbus_src;
    logic drv_q;
    logic [`MQ_THR_W-1:0] ae_thr_q, af_thr_q;
    logic wr_take;
    logic rd_take;
    logic [31:0] stat;

    // Every host pin crosses in through two flops; only stage two is read
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (ce) begin
            sync1_q <= {master_reset_n, partial_reset_n, input_width_select,
                        output_width_select, bus_match_select,
                        flag_mode_select, packet_mode_select,
                        write_queue_address, write_address_enable,
                        read_queue_address, read_address_enable,
                        write_flag_sector_strobe, read_flag_sector_strobe,
                        write_strobe, read_strobe, packet_start_marker,
                        packet_end_marker, read_packet_end};
            sync2_q <= sync1_q;
        end
    end

    assign {mrs_n_s, prs_n_s, iw_s, ow_s, bm_s, fm_s, pkt_s, wqa_s, wae_s,
            rqa_s, rae_s, wfs_s, rfs_s, ws_s, rs_s, psm_s, pem_s,
            rpe_s} = sync2_q;

    // Master reset: the bus reset or the master reset pin held low
    assign mr = rst | ~mrs_n_s;

    // Straps follow their pins while master reset lasts, then hold
    always_ff @(posedge clk) begin
        if (rst) begin
            in_w_q <= mq_flag_pkg::W36;
            out_w_q <= mq_flag_pkg::W36;
            pkt_req_q <= 1'b0;
            pkt_mode_q <= 1'b0;
            polled_q <= 1'b0;
        end else if (ce && mr) begin
            polled_q <= fm_s;
            pkt_req_q <= pkt_s;
            // A packet request is honoured only with x36 on both sides
            pkt_mode_q <= pkt_s & ~bm_s;
            if (!bm_s) begin
                in_w_q <= mq_flag_pkg::W36;
                out_w_q <= mq_flag_pkg::W36;
            end else if (!iw_s) begin
                in_w_q <= mq_flag_pkg::W36;
                out_w_q <= ow_s ? mq_flag_pkg::W9 : mq_flag_pkg::W18;
            end else begin
                in_w_q <= ow_s ? mq_flag_pkg::W9 : mq_flag_pkg::W18;
                out_w_q <= mq_flag_pkg::W36;
            end
        end
    end

    // Queue selection on both ports; a read select restarts valid delay
    always_ff @(posedge clk) begin
        if (mr) begin
            wq_q <= '0;
            rq_q <= '0;
            ov_dly_q <= `MQ_OV_DELAY;
        end else if (ce) begin
            if (wae_s) begin
                wq_q <= wqa_s;
            end
            if (rae_s) begin
                rq_q <= rqa_s;
                ov_dly_q <= `MQ_OV_DELAY;
            end else if (ov_dly_q != 2'h0) begin
                ov_dly_q <= ov_dly_q - 2'h1;
            end
        end
    end

    // Open-packet tracking; the host keeps a packet in one queue
    always_ff @(posedge clk) begin
        if (mr) begin
            in_pkt_q <= 1'b0;
        end else if (ce && ws_s && pkt_mode_q) begin
            // An end marker closes the packet, even a one-word packet
            if (pem_s) begin
                in_pkt_q <= 1'b0;
            end else if (psm_s) begin
                in_pkt_q <= 1'b1;
            end
        end
    end

    // Per-queue occupancy and complete-packet counts
    for (genvar q = 0; q < `MQ_NQ; q++) begin : g_queue
        logic [CW-1:0] cnt_q;
        logic [CW-1:0] pkts_q;
        logic wsel, rsel, wr_ok, rd_ok, pkt_done, pkt_gone;
        logic [`MQ_THR_W-1:0] cnt_t;

        assign wsel = (wq_q == `MQ_QW'(q));
        assign rsel = (rq_q == `MQ_QW'(q));
        assign wr_ok = ws_s & wsel & (cnt_q != DEPTH_C);
        assign rd_ok = rs_s & rsel & (cnt_q != '0);
        assign pkt_done = wr_ok & pkt_mode_q & pem_s & (in_pkt_q | psm_s);
        assign pkt_gone = rd_ok & pkt_mode_q & rpe_s & (pkts_q != '0);
        assign cnt_t = `MQ_THR_W'(cnt_q);

        // Partial reset needs the queue selected on both ports first
        always_ff @(posedge clk) begin
            if (mr) begin
                cnt_q <= '0;
                pkts_q <= '0;
            end else if (ce) begin
                if (!prs_n_s && wsel && rsel) begin
                    cnt_q <= '0;
                    pkts_q <= '0;
                end else begin
                    cnt_q <= cnt_q + CW'(wr_ok) - CW'(rd_ok);
                    pkts_q <= pkts_q + CW'(pkt_done) - CW'(pkt_gone);
                end
            end
        end

        assign emp_st[q] = (cnt_q == '0);
        assign ae_st[q] = (cnt_t <= ae_thr_q);
        assign af_st[q] = (af_thr_q >= DEPTH_T) ||
                          (cnt_t >= DEPTH_T - af_thr_q);
        assign pr_st[q] = (pkts_q != '0);
    end

    // Read bus carries packet-ready status in packet mode
    assign rbus_src = pkt_mode_q ? ~pr_st : ~ae_st;

    // Discrete flags, registered so they change only on the clock edge
    always_ff @(posedge clk) begin
        if (mr) begin
            output_valid_flag <= 1'b1;
            almost_empty_flag <= 1'b1;
            almost_full_flag <= 1'b1;
            packet_ready_flag <= 1'b1;
        end else if (ce) begin
            // Held invalid while the output path refills after a select
            output_valid_flag <= (ov_dly_q != 2'h0) | emp_st[rq_q];
            almost_empty_flag <= ~ae_st[rq_q];
            almost_full_flag <= ~af_st[wq_q];
            // Inactive high outside packet mode
            packet_ready_flag <= ~(pkt_mode_q & pr_st[rq_q]);
        end
    end

    // Sector choice: strobe driven when direct, free running when polled
    always_ff @(posedge clk) begin
        if (mr) begin
            rd_sec_q <= 1'b0;
            wr_sec_q <= 1'b0;
        end else if (ce) begin
            if (polled_q) begin
                rd_sec_q <= ~rd_sec_q;
                wr_sec_q <= ~wr_sec_q;
            end else begin
                if (rfs_s) begin
                    rd_sec_q <= rqa_s[`MQ_QW-1];
                end
                if (wfs_s) begin
                    wr_sec_q <= wqa_s[`MQ_QW-1];
                end
            end
        end
    end

    // Flag buses show one sector, one line per queue of that sector, chosen apart from the selected queue
    always_ff @(posedge clk) begin
        if (mr) begin
            almost_empty_flag_bus <= '1;
            almost_full_flag_bus <= '1;
        end else if (ce) begin
            almost_empty_flag_bus <= rbus_src[rd_sec_q*`MQ_SECT +: `MQ_SECT];
            almost_full_flag_bus <= ~af_st[wr_sec_q*`MQ_SECT +: `MQ_SECT];
        end
    end

    // The valid flag and both flag buses release their wires when software turns driving off,
    // which lets several devices share one flag wiring
    assign output_valid_flag_oe = drv_q;
    assign almost_empty_flag_bus_oe = drv_q;
    assign almost_full_flag_bus_oe = drv_q;

    // Write channel: address and data taken together, one at a time
    assign wr_take = ce & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = wr_take;
    assign s_axi_wready = wr_take;

    always_ff @(posedge clk) begin
        if (rst) begin
            drv_q <= `MQ_CTRL_DRV_RST;
            ae_thr_q <= `MQ_AE_RST;
            af_thr_q <= `MQ_AF_RST;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MQ_RESP_OKAY;
        end else if (ce) begin
            if (wr_take) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `MQ_RESP_OKAY;
                // Only the low byte lane matters for the control bit
                unique case (s_axi_awaddr)
                    `MQ_ADDR_CTRL: begin
                        if (s_axi_wstrb[0]) begin
                            drv_q <= s_axi_wdata[`MQ_CTRL_DRV];
                        end
                    end
                    `MQ_ADDR_AE: begin
                        for (int b = 0; b < 2; b++) begin
                            if (s_axi_wstrb[b]) begin
                                ae_thr_q[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
                            end
                        end
                    end
                    `MQ_ADDR_AF: begin
                        for (int b = 0; b < 2; b++) begin
                            if (s_axi_wstrb[b]) begin
                                af_thr_q[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
                            end
                        end
                    end
                    `MQ_ADDR_STAT: begin
                        s_axi_bresp <= `MQ_RESP_OKAY;
                    end
                    default: begin
                        s_axi_bresp <= `MQ_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Status word: latched configuration and live selections
    always_comb begin
        stat = '0;
        stat[`MQ_ST_PKT] = pkt_mode_q;
        stat[`MQ_ST_POLL] = polled_q;
        stat[`MQ_ST_INW +: 2] = in_w_q;
        stat[`MQ_ST_OUTW +: 2] = out_w_q;
        stat[`MQ_ST_RQ +: `MQ_QW] = rq_q;
        stat[`MQ_ST_WQ +: `MQ_QW] = wq_q;
        stat[`MQ_ST_RSEC] = rd_sec_q;
        stat[`MQ_ST_WSEC] = wr_sec_q;
        // Packet mode asked for without x36 on both ports
        stat[`MQ_ST_CFGERR] = pkt_req_q & ~pkt_mode_q;
    end

    // Read channel: one read under way, answered the next cycle
    assign rd_take = ce & s_axi_arvalid & ~s_axi_rvalid;
    assign s_axi_arready = rd_take;

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `MQ_RESP_OKAY;
        end else if (ce) begin
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `MQ_RESP_OKAY;
                unique case (s_axi_araddr)
                    `MQ_ADDR_CTRL: s_axi_rdata <= 32'(drv_q);
                    `MQ_ADDR_AE: s_axi_rdata <= 32'(ae_thr_q);
                    `MQ_ADDR_AF: s_axi_rdata <= 32'(af_thr_q);
                    `MQ_ADDR_STAT: s_axi_rdata <= stat;
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= `MQ_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence read_select_s;
        ce && rae_s && !mr;
    endsequence

    // Valid flag held high at the second edge after a select
    ov_delay_a: assert property (
        read_select_s ##1 ce |=> output_valid_flag)
        else $error("valid flag not held after read select");

    ov_empty_a: assert property (
        ce && ov_dly_q == 2'h0 && emp_st[rq_q] |=> output_valid_flag)
        else $error("valid flag low on empty read queue");

    read_select_a: assert property (
        read_select_s |=> rq_q == $past(rqa_s))
        else $error("read queue not taken");

    pkt_width_a: assert property (
        pkt_mode_q |-> in_w_q == mq_flag_pkg::W36 &&
        out_w_q == mq_flag_pkg::W36)
        else $error("packet mode without x36 ports");

    pr_idle_a: assert property (
        (!pkt_mode_q && !mr) [*2] |-> packet_ready_flag)
        else $error("packet flag active outside packet mode");

    poll_read_a: assert property (
        ce && !mr && polled_q |=> rd_sec_q != $past(rd_sec_q))
        else $error("read sector did not advance");

    poll_write_a: assert property (
        ce && !mr && polled_q |=> wr_sec_q != $past(wr_sec_q))
        else $error("write sector did not advance");

    direct_read_a: assert property (
        ce && !mr && !polled_q && rfs_s |=>
        rd_sec_q == $past(rqa_s[`MQ_QW-1]))
        else $error("read sector strobe ignored");

    partial_clr_a: assert property (
        ce && !mr && !prs_n_s && wq_q == rq_q |=> emp_st[$past(rq_q)])
        else $error("partial reset left queue occupied");

    cfg_hold_a: assert property (
        !mr ##1 !mr |-> $stable(polled_q) && $stable(pkt_mode_q))
        else $error("configuration changed outside master reset");

    // Flag follows the selected write queue's status one edge later
    af_flag_a: assert property (
        ce && !mr |=> almost_full_flag == !$past(af_st[wq_q]))
        else $error("almost full flag missed");

endmodule

`default_nettype wire
